/* core/irq_flag_pkg.sv */
// constants shared by the peripheral interrupt flag bank
package irq_flag_pkg;

  // apb geometry
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;
  localparam int          REG_W  = 8;

  // register byte offsets
  localparam logic [11:0] OFF_CORE_CTRL   = 12'h000;
  localparam logic [11:0] OFF_OPTION      = 12'h004;
  localparam logic [11:0] OFF_EN_TIMERS   = 12'h008;
  localparam logic [11:0] OFF_EN_COMP_OSC = 12'h00C;
  localparam logic [11:0] OFF_EN_CELLS    = 12'h010;
  localparam logic [11:0] OFF_FL_TIMERS   = 12'h014;
  localparam logic [11:0] OFF_FL_COMP_OSC = 12'h018;
  localparam logic [11:0] OFF_FL_CELLS    = 12'h01C;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h020;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h024;

  // core control fields
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;

  // timers/converter flag and enable fields
  localparam int TIMER_GATE_BIT = 7;
  localparam int CONV_DONE_BIT  = 6;
  localparam int TIMER_TWO_BIT  = 1;
  localparam int TIMER_ONE_BIT  = 0;

  // comparator/oscillator flag and enable fields
  localparam int COMP_ONE_BIT  = 5;
  localparam int ACCUM_OSC_BIT = 2;

  // logic cell flag and enable fields
  localparam int CELL_TWO_BIT = 1;
  localparam int CELL_ONE_BIT = 0;

  // implemented bit masks
  localparam logic [7:0] IMPL_CORE_CTRL = 8'hFF;
  localparam logic [7:0] IMPL_OPTION    = 8'hFF;
  localparam logic [7:0] IMPL_TIMERS    = 8'hC3;
  localparam logic [7:0] IMPL_COMP_OSC  = 8'h24;
  localparam logic [7:0] IMPL_CELLS     = 8'h03;

  // reset values
  localparam logic [7:0] RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] RST_OPTION    = 8'h00;
  localparam logic [7:0] RST_ENABLES   = 8'h00;
  localparam logic [7:0] RST_FLAGS     = 8'h00;
  localparam logic [7:0] RST_IRQ       = 8'h00;

  // sticky status event positions
  localparam int EV_TIMER_ONE  = 0;
  localparam int EV_TIMER_TWO  = 1;
  localparam int EV_CONV_DONE  = 2;
  localparam int EV_TIMER_GATE = 3;
  localparam int EV_ACCUM_OSC  = 4;
  localparam int EV_COMP_ONE   = 5;
  localparam int EV_CELL_ONE   = 6;
  localparam int EV_CELL_TWO   = 7;

  // apb handshake states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_e;

endpackage

/* core/flag_port_if.sv */
// carrier between the bank top and one flag register
`timescale 1ns/1ns
interface flag_port_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] event_set;
  logic [7:0] value;

  modport bank (input wr, input wdata, input event_set, output value);
  modport ctrl (output wr, output wdata, output event_set, input value);
endinterface

/* core/irq_flag_reg.sv */
// one 8-bit event flag register with software write
`timescale 1ns/1ns
module irq_flag_reg
  import irq_flag_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hFF
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  flag_port_if.bank  port
);

  logic [7:0] flags;
  logic [7:0] next_flags;

  // events set regardless of any enable; a set wins over a write of zero
  always_comb begin
    next_flags = flags;
    if (port.wr) begin
      next_flags = port.wdata;
    end
    next_flags = (next_flags | port.event_set) & IMPL;
  end

  // flags clear on every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  assign port.value = flags;

endmodule // irq_flag_reg

/* core/peripheral_irq_flag_bank.sv */
// peripheral interrupt flag bank with apb register access
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module peripheral_irq_flag_bank
  import irq_flag_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer_one_overflow_event,
  input  wire logic              timer_two_match_event,
  input  wire logic              converter_done_event,
  input  wire logic              timer_one_gate_event,
  input  wire logic              accum_oscillator_event,
  input  wire logic              comparator_one_event,
  input  wire logic              logic_cell_one_event,
  input  wire logic              logic_cell_two_event,
  output logic                   core_irq_request,
  output logic                   core_wake_request,
  output logic                   irq
);

  // address match against one word-aligned register offset
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] off);
    hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // true for any offset that holds a register
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hit(addr, OFF_CORE_CTRL)   || hit(addr, OFF_OPTION)      ||
             hit(addr, OFF_EN_TIMERS)   || hit(addr, OFF_EN_COMP_OSC) ||
             hit(addr, OFF_EN_CELLS)    || hit(addr, OFF_FL_TIMERS)   ||
             hit(addr, OFF_FL_COMP_OSC) || hit(addr, OFF_FL_CELLS)    ||
             hit(addr, OFF_IRQ_STATUS)  || hit(addr, OFF_IRQ_MASK);
  endfunction

  bus_state_e        state;
  bus_state_e        next_state;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;

  logic [7:0]        core_ctrl;
  logic [7:0]        option_ctrl;
  logic [7:0]        en_timers;
  logic [7:0]        en_comp_osc;
  logic [7:0]        en_cells;
  logic [7:0]        irq_status;
  logic [7:0]        irq_mask;
  logic [7:0]        next_core_ctrl;
  logic [7:0]        next_option_ctrl;
  logic [7:0]        next_en_timers;
  logic [7:0]        next_en_comp_osc;
  logic [7:0]        next_en_cells;
  logic [7:0]        next_irq_status;
  logic [7:0]        next_irq_mask;
  logic              next_irq;
  logic              next_core_irq_request;
  logic              next_core_wake_request;

  logic              done;
  logic              wr_ok;
  logic              rd_ok;
  logic [7:0]        wbyte;
  logic [7:0]        ev;
  logic [7:0]        pend_timers;
  logic [7:0]        pend_comp_osc;
  logic [7:0]        pend_cells;
  logic              periph_pending;

  flag_port_if fl_timers ();
  flag_port_if fl_comp_osc ();
  flag_port_if fl_cells ();

  // the three flag registers share one module, differing only in mask
  irq_flag_reg #(.IMPL(IMPL_TIMERS)) u_flags_timers (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (fl_timers.bank)
  );

  irq_flag_reg #(.IMPL(IMPL_COMP_OSC)) u_flags_comp_osc (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (fl_comp_osc.bank)
  );

  irq_flag_reg #(.IMPL(IMPL_CELLS)) u_flags_cells (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (fl_cells.bank)
  );

  // transfer completes on the edge where pready is seen high
  assign done  = psel && penable && pready;
  assign wr_ok = done && pwrite && !pslverr && pstrb[0];
  assign rd_ok = done && !pwrite && !pslverr;
  assign wbyte = pwdata[7:0];

  // gather events into the sticky status layout
  always_comb begin
    ev                = 8'h00;
    ev[EV_TIMER_ONE]  = timer_one_overflow_event;
    ev[EV_TIMER_TWO]  = timer_two_match_event;
    ev[EV_CONV_DONE]  = converter_done_event;
    ev[EV_TIMER_GATE] = timer_one_gate_event;
    ev[EV_ACCUM_OSC]  = accum_oscillator_event;
    ev[EV_COMP_ONE]   = comparator_one_event;
    ev[EV_CELL_ONE]   = logic_cell_one_event;
    ev[EV_CELL_TWO]   = logic_cell_two_event;
  end

  // route events to their flag bits, independent of enables
  always_comb begin
    fl_timers.event_set                   = 8'h00;
    fl_timers.event_set[TIMER_GATE_BIT]   = timer_one_gate_event;
    fl_timers.event_set[CONV_DONE_BIT]    = converter_done_event;
    fl_timers.event_set[TIMER_TWO_BIT]    = timer_two_match_event;
    fl_timers.event_set[TIMER_ONE_BIT]    = timer_one_overflow_event;
    fl_comp_osc.event_set                 = 8'h00;
    fl_comp_osc.event_set[COMP_ONE_BIT]   = comparator_one_event;
    fl_comp_osc.event_set[ACCUM_OSC_BIT]  = accum_oscillator_event;
    fl_cells.event_set                    = 8'h00;
    fl_cells.event_set[CELL_TWO_BIT]      = logic_cell_two_event;
    fl_cells.event_set[CELL_ONE_BIT]      = logic_cell_one_event;
  end

  // software writes to the flag registers
  always_comb begin
    fl_timers.wr     = wr_ok && hit(paddr, OFF_FL_TIMERS);
    fl_comp_osc.wr   = wr_ok && hit(paddr, OFF_FL_COMP_OSC);
    fl_cells.wr      = wr_ok && hit(paddr, OFF_FL_CELLS);
    fl_timers.wdata   = wbyte;
    fl_comp_osc.wdata = wbyte;
    fl_cells.wdata    = wbyte;
  end

  // apb handshake: one wait cycle so read data can come from a flop
  always_comb begin
    next_state   = state;
    next_pready  = 1'b0;
    next_pslverr = pslverr;
    next_prdata  = prdata;
    unique case (state)
      ST_IDLE: begin
        if (psel && penable) begin
          next_state   = ST_ACK;
          next_pready  = 1'b1;
          next_pslverr = !mapped(paddr);
          next_prdata  = '0;
          if (!pwrite) begin
            if (hit(paddr, OFF_CORE_CTRL)) begin
              next_prdata[7:0] = core_ctrl & IMPL_CORE_CTRL;
            end else if (hit(paddr, OFF_OPTION)) begin
              next_prdata[7:0] = option_ctrl & IMPL_OPTION;
            end else if (hit(paddr, OFF_EN_TIMERS)) begin
              next_prdata[7:0] = en_timers;
            end else if (hit(paddr, OFF_EN_COMP_OSC)) begin
              next_prdata[7:0] = en_comp_osc;
            end else if (hit(paddr, OFF_EN_CELLS)) begin
              next_prdata[7:0] = en_cells;
            end else if (hit(paddr, OFF_FL_TIMERS)) begin
              next_prdata[7:0] = fl_timers.value;
            end else if (hit(paddr, OFF_FL_COMP_OSC)) begin
              next_prdata[7:0] = fl_comp_osc.value;
            end else if (hit(paddr, OFF_FL_CELLS)) begin
              next_prdata[7:0] = fl_cells.value;
            end else if (hit(paddr, OFF_IRQ_STATUS)) begin
              next_prdata[7:0] = irq_status;
            end else if (hit(paddr, OFF_IRQ_MASK)) begin
              next_prdata[7:0] = irq_mask;
            end
          end
        end
      end
      ST_ACK: begin
        next_state   = ST_IDLE;
        next_pslverr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      state   <= next_state;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // control and enable storage; unimplemented bits masked off
  always_comb begin
    next_core_ctrl   = core_ctrl;
    next_option_ctrl = option_ctrl;
    next_en_timers   = en_timers;
    next_en_comp_osc = en_comp_osc;
    next_en_cells    = en_cells;
    next_irq_mask    = irq_mask;
    if (wr_ok && hit(paddr, OFF_CORE_CTRL)) begin
      next_core_ctrl = wbyte & IMPL_CORE_CTRL;
    end
    if (wr_ok && hit(paddr, OFF_OPTION)) begin
      next_option_ctrl = wbyte & IMPL_OPTION;
    end
    if (wr_ok && hit(paddr, OFF_EN_TIMERS)) begin
      next_en_timers = wbyte & IMPL_TIMERS;
    end
    if (wr_ok && hit(paddr, OFF_EN_COMP_OSC)) begin
      next_en_comp_osc = wbyte & IMPL_COMP_OSC;
    end
    if (wr_ok && hit(paddr, OFF_EN_CELLS)) begin
      next_en_cells = wbyte & IMPL_CELLS;
    end
    if (wr_ok && hit(paddr, OFF_IRQ_MASK)) begin
      next_irq_mask = wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl   <= RST_CORE_CTRL;
      option_ctrl <= RST_OPTION;
      en_timers   <= RST_ENABLES;
      en_comp_osc <= RST_ENABLES;
      en_cells    <= RST_ENABLES;
      irq_mask    <= RST_IRQ;
    end else begin
      core_ctrl   <= next_core_ctrl;
      option_ctrl <= next_option_ctrl;
      en_timers   <= next_en_timers;
      en_comp_osc <= next_en_comp_osc;
      en_cells    <= next_en_cells;
      irq_mask    <= next_irq_mask;
    end
  end

  // sticky status clears on read, but an event in that cycle survives
  always_comb begin
    next_irq_status = irq_status;
    if (rd_ok && hit(paddr, OFF_IRQ_STATUS)) begin
      next_irq_status = 8'h00;
    end
    next_irq_status = next_irq_status | ev;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_IRQ;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= next_irq;
    end
  end

  // request gating; a stale flag fires as soon as its enable is written
  always_comb begin
    pend_timers    = fl_timers.value & en_timers;
    pend_comp_osc  = fl_comp_osc.value & en_comp_osc;
    pend_cells     = fl_cells.value & en_cells;
    periph_pending = (|pend_timers) || (|pend_comp_osc) || (|pend_cells);
    next_core_wake_request = periph_pending && core_ctrl[PERIPH_EN_BIT];
    next_core_irq_request  = next_core_wake_request &&
                             core_ctrl[GLOBAL_EN_BIT];
  end

  // registered so the core sees glitch-free levels, at one cycle of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_wake_request <= 1'b0;
      core_irq_request  <= 1'b0;
    end else begin
      core_wake_request <= next_core_wake_request;
      core_irq_request  <= next_core_irq_request;
    end
  end

endmodule // peripheral_irq_flag_bank

/* verification/event_source_model.sv */
// event source model: one-cycle event pulses on request
`timescale 1ns/1ns
module event_source_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] fire,
  output logic      [7:0] ev
);
  // launched off a clock edge, as a real peripheral would, so no race at the bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= 8'h00;
    end else begin
      ev <= fire;
    end
  end
endmodule // event_source_model

/* verification/peripheral_irq_flag_bank_properties.sv */
// concurrent checks on the flag bank ports
`timescale 1ns/1ns
module peripheral_irq_flag_bank_properties
  import irq_flag_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              comparator_one_event,
  input wire logic              core_irq_request,
  input wire logic              core_wake_request,
  input wire logic              irq
);
  logic [7:0] ctrl;
  logic [7:0] en_co;
  logic       wr_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow copies, updated on the same edge as the bank's own write
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= 8'h00;
      en_co <= 8'h00;
    end else if (wr_ok && paddr[ADDR_W-1:2] == OFF_CORE_CTRL[ADDR_W-1:2]) begin
      ctrl <= pwdata[7:0];
    end else if (wr_ok && paddr[ADDR_W-1:2] == OFF_EN_COMP_OSC[ADDR_W-1:2]) begin
      en_co <= pwdata[7:0];
    end
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  wait_state_a: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  periph_gate_a: assert property (!ctrl[PERIPH_EN_BIT] |=> !core_wake_request)
    else $error("wake without peripheral enable");
  global_gate_a: assert property (!ctrl[GLOBAL_EN_BIT] |=> !core_irq_request)
    else $error("request without global enable");
  req_has_wake_a: assert property (core_irq_request |-> core_wake_request)
    else $error("request without wake condition");
  comp_wake_a: assert property (comparator_one_event && en_co[COMP_ONE_BIT]
    && ctrl[PERIPH_EN_BIT] |-> ##2 core_wake_request)
    else $error("comparator event did not wake");
  // main scenarios reached
  cover property (core_irq_request);
  cover property (pslverr);
  cover property (irq && !core_irq_request);
endmodule // peripheral_irq_flag_bank_properties

bind peripheral_irq_flag_bank peripheral_irq_flag_bank_properties u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .comparator_one_event, .core_irq_request, .core_wake_request, .irq);

/* verification/peripheral_irq_flag_bank_test.sv */
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ns
module peripheral_irq_flag_bank_test
  import irq_flag_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        core_irq_request, core_wake_request, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  fire, ev;
  int          n_mismatch, check_count, cycles;
  // event order follows the status bit positions
  logic [11:0] ev_off [8] = '{OFF_FL_TIMERS, OFF_FL_TIMERS, OFF_FL_TIMERS, OFF_FL_TIMERS,
    OFF_FL_COMP_OSC, OFF_FL_COMP_OSC, OFF_FL_CELLS, OFF_FL_CELLS};
  int          ev_bit [8] = '{0, 1, 6, 7, 2, 5, 0, 1};
  logic [11:0] reg_off [8] = '{OFF_CORE_CTRL, OFF_OPTION, OFF_EN_TIMERS, OFF_EN_COMP_OSC,
    OFF_EN_CELLS, OFF_FL_TIMERS, OFF_FL_COMP_OSC, OFF_FL_CELLS};
  logic [7:0]  reg_msk [8] = '{8'hFF, 8'hFF, 8'hC3, 8'h24, 8'h03, 8'hC3, 8'h24, 8'h03};

  event_source_model u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .ev(ev));
  peripheral_irq_flag_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one_overflow_event(ev[EV_TIMER_ONE]), .timer_two_match_event(ev[EV_TIMER_TWO]),
    .converter_done_event(ev[EV_CONV_DONE]), .timer_one_gate_event(ev[EV_TIMER_GATE]),
    .accum_oscillator_event(ev[EV_ACCUM_OSC]), .comparator_one_event(ev[EV_COMP_ONE]),
    .logic_cell_one_event(ev[EV_CELL_ONE]), .logic_cell_two_event(ev[EV_CELL_TWO]),
    .core_irq_request(core_irq_request), .core_wake_request(core_wake_request), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered and left just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the cycle ceiling ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // one-cycle event, then time for flag and outputs to settle
  task automatic pulse(input int i);
    fire <= 8'h01 << i;
    @(posedge pclk);
    fire <= 8'h00;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_regs;
    rdchk(OFF_IRQ_STATUS, 32'h0);
    rdchk(OFF_IRQ_MASK, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rdchk(reg_off[i], 32'h0);
      apb(reg_off[i], 1'b1, 32'hFFFF_FFFF);
      rdchk(reg_off[i], {24'h0, reg_msk[i]});
      apb(reg_off[i], 1'b1, 32'h0);
      rdchk(reg_off[i], 32'h0);
    end
    // a write with byte lane zero off must be dropped
    apb(OFF_OPTION, 1'b1, 32'hA5);
    pstrb <= 4'hE;
    apb(OFF_OPTION, 1'b1, 32'h0);
    pstrb <= 4'hF;
    rdchk(OFF_OPTION, 32'hA5);
    apb(12'h028, 1'b1, 32'hFF);
    chk(32'(er), 32'h1);
    rdchk(12'h028, 32'h0);
    chk(32'(er), 32'h1);
    $display("t_regs done");
  endtask

  task automatic t_events;
    apb(OFF_IRQ_MASK, 1'b1, 32'h7F);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rdchk(ev_off[i], 32'h1 << ev_bit[i]);
      chk(32'(irq), 32'(i < 7));
      chk(32'(core_irq_request), 32'h0);
      rdchk(OFF_IRQ_STATUS, 32'h1 << i);
      rdchk(OFF_IRQ_STATUS, 32'h0);
      chk(32'(irq), 32'h0);
      apb(ev_off[i], 1'b1, 32'h0);
      rdchk(ev_off[i], 32'h0);
    end
    $display("t_events done");
  endtask

  task automatic t_request;
    apb(OFF_FL_COMP_OSC, 1'b1, 32'h0);
    apb(OFF_EN_COMP_OSC, 1'b1, 32'h20);
    apb(OFF_CORE_CTRL, 1'b1, 32'h40);
    pulse(EV_COMP_ONE);
    chk(32'(core_wake_request), 32'h1);
    chk(32'(core_irq_request), 32'h0);
    apb(OFF_CORE_CTRL, 1'b1, 32'hC0);
    repeat (2) @(posedge pclk);
    chk(32'(core_irq_request), 32'h1);
    apb(OFF_CORE_CTRL, 1'b1, 32'h80);
    repeat (2) @(posedge pclk);
    chk(32'(core_wake_request), 32'h0);
    chk(32'(core_irq_request), 32'h0);
    apb(OFF_CORE_CTRL, 1'b1, 32'hC0);
    apb(OFF_FL_COMP_OSC, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(core_irq_request), 32'h0);
    rdchk(OFF_IRQ_STATUS, 32'h20);
    $display("t_request done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    fire = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_events();
    t_request();
    report_and_stop();
  end
endmodule // peripheral_irq_flag_bank_test
